/* File: core/axis_hold_pkg.sv */
// constants shared by the axis hold and home logic
package axis_hold_pkg;
	// geometry
	localparam int NUM_AXES = 4;
	localparam int DW       = 32;
	localparam int AW       = 4;
	// register offsets
	localparam logic [3:0] OFS_CTRL     = 4'h0;
	localparam logic [3:0] OFS_TYPES    = 4'h1;
	localparam logic [3:0] OFS_COMMAND  = 4'h2;
	localparam logic [3:0] OFS_DEADBAND = 4'h3;
	localparam logic [3:0] OFS_GAIN     = 4'h4;
	localparam logic [3:0] OFS_VCAP     = 4'h5;
	localparam logic [3:0] OFS_STATUS   = 4'h6;
	localparam logic [3:0] OFS_COST     = 4'h7;
	localparam logic [3:0] OFS_TARGET   = 4'h8;
	localparam logic [3:0] OFS_RAMP_UP  = 4'h9;
	localparam logic [3:0] OFS_RAMP_DN  = 4'hA;
	localparam logic [3:0] OFS_HOMECFG  = 4'hB;
	// control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_AXIS_LSB = 2;
	localparam int CTRL_PA_BIT   = 4;
	localparam int CTRL_SET_BIT  = 5;
	// command and value register fields
	localparam int CMD_MASK_LSB = 4;
	localparam int CMD_POL_LSB  = 8;
	localparam int VAL_MASK_LSB = 16;
	// status register fields
	localparam int ST_REJ_BIT = 8;
	localparam int ST_BAD_BIT = 9;
	localparam int ST_HOM_LSB = 12;
	// axis operating modes
	typedef enum logic [1:0] {
		MODE_SINGLE = 2'h0,
		MODE_ALL    = 2'h1,
		MODE_MIXED  = 2'h2
	} mode_t;
	// axis kinds
	typedef enum logic [1:0] {
		KIND_STEP   = 2'h0,
		KIND_STEPEN = 2'h1,
		KIND_SERVO  = 2'h2
	} kind_t;
	// command opcodes
	typedef enum logic [3:0] {
		OP_NONE     = 4'h0,
		OP_GO_ASYM  = 4'h1,
		OP_HOLD_OFF = 4'h2,
		OP_HOLD_ON  = 4'h3,
		OP_HOME_ENC = 4'h4,
		OP_HOME_SW  = 4'h5,
		OP_HOME_LO  = 4'h6,
		OP_HOME_HI  = 4'h7,
		OP_ENC_POL  = 4'h8,
		OP_SAVE     = 4'h9
	} op_t;
	// ranges and defaults
	localparam logic [15:0] DEADBAND_MAX = 16'hFA00;
	localparam logic [15:0] GAIN_MIN     = 16'h0001;
	localparam logic [15:0] GAIN_MAX     = 16'h7D00;
	localparam logic [15:0] DEADBAND_RST = 16'h0000;
	localparam logic [15:0] GAIN_RST     = 16'h0001;
	localparam logic        HOME_POL_RST = 1'b0;
	localparam logic [2:0]  ENC_POL_RST  = 3'h6;
	localparam logic [15:0] VCAP_RST     = 16'h0000;
	// queue costs
	localparam logic [3:0] COST_GO_BASE   = 4'h3;
	localparam logic [3:0] COST_FB_CMD    = 4'h1;
	localparam logic [3:0] COST_FB_ARG    = 4'h2;
	localparam logic [3:0] COST_PA_CMD    = 4'h2;
	localparam logic [3:0] COST_SET_CMD   = 4'h2;
	localparam logic [3:0] COST_SET_ARG   = 4'h1;
	localparam logic [3:0] COST_HF_ST_CMD = 4'h2;
	localparam logic [3:0] COST_HF_SV_CMD = 4'h1;
	localparam logic [3:0] COST_HF_SV_ARG = 4'h1;
endpackage

/* File: core/pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             REF_CLK,
	input  wire logic             RST,
	input  wire logic [WIDTH-1:0] PIN_IN,
	output logic      [WIDTH-1:0] PIN_OUT
);
	logic [WIDTH-1:0] s1_q;  // first stage, read only by s2
	logic [WIDTH-1:0] s2_q;  // second stage
	logic [WIDTH-1:0] s3_q;  // third stage
	logic [WIDTH-1:0] agree; // bits where stages two and three match

	assign agree = ~(s2_q ^ s3_q);

	// shift chain; output follows only agreeing bits
	always_ff @(posedge REF_CLK)
	begin
		s1_q    <= PIN_IN;
		s2_q    <= s1_q;
		s3_q    <= s2_q;
		if (RST)
			PIN_OUT <= '0;
		else
			PIN_OUT <= (agree & s3_q) | (~agree & PIN_OUT);
	end
endmodule // pin_sync

/* File: core/axis_hold_and_home_logic.sv */
// per-axis go, position hold and home qualification logic
//
// Summary of operation
// RQ1 - asymmetric go uses ramp-up and ramp-down rates
// RQ2 - asymmetric go single axis only
// RQ3 - host: linear ramps, one go per move
// RQ4 - asymmetric go costs three, plus feedback extra
// RQ5 - power automatic adds two command entries
// RQ6 - settle time adds two command, one argument
// RQ7 - within deadband: in position, no correction
// RQ8 - deadband zero to 64000, default zero, savable
// RQ9 - deadband query immediate, stepper-encoder, single only
// RQ10 - encoder homing qualifies home, starts nothing
// RQ11 - encoder home: index, switch, A high B low
// RQ12 - switch-only homing restores switch-only detection
// RQ13 - home switch and encoder polarities configurable
// RQ14 - hold off disables stepper-encoder hold features
// RQ15 - hold off opens servo loop, PID off
// RQ16 - hold off in multi-axis opens all axes
// RQ17 - multi-axis hold off with an argument opens only the listed axes
// RQ18 - reset starts all axes open loop
// RQ19 - hold off cost by axis kind
// RQ20 - correction velocity is error times gain
// RQ21 - correction velocity clamped to velocity cap
// RQ22 - gain one to 32000, default one, savable
// RQ23 - out-of-range deadband or gain rejected
`timescale 1ns/10ps
module axis_hold_and_home_logic (
	input  wire logic        REF_CLK,
	input  wire logic        RST,
	input  wire logic        PWR_ON_RST,
	input  wire logic [3:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [31:0] RDATA,
	input  wire logic [31:0] ENC_COUNT,
	input  wire logic [3:0]  HOME_SW,
	input  wire logic [3:0]  ENC_IDX,
	input  wire logic [3:0]  ENC_A,
	input  wire logic [3:0]  ENC_B,
	output logic             GO_START,
	output logic      [15:0] ACCEL_RATE,
	output logic      [15:0] DECEL_RATE,
	output logic      [3:0]  HOLD_EN,
	output logic      [3:0]  LOOP_CLOSED,
	output logic      [15:0] CORR_VEL,
	output logic             CORR_DIR,
	output logic             IN_POSITION,
	output logic      [3:0]  HOME_FOUND
);
	// magnitude of a signed word
	function automatic logic [31:0] mag(input logic [31:0] v);
		mag = v[31] ? (32'h0000_0000 - v) : v;
	endfunction

	// axes addressed by a command: current axis, or the mask
	function automatic logic [3:0] sel_axes(
		input logic [1:0] mode,
		input logic [1:0] axis,
		input logic [3:0] mask
	);
		sel_axes = (mode == axis_hold_pkg::MODE_SINGLE) ?
			(4'h1 << axis) : mask;
	endfunction

	// configuration
	logic [1:0]  mode_q;          // operating mode
	logic [1:0]  axis_q;          // current axis
	logic        pa_q;            // power automatic active
	logic        settle_q;        // aux bit settle time set
	logic [7:0]  kinds_q;         // two bits per axis
	logic [15:0] vcap_q;          // hold velocity cap
	logic [31:0] target_q;        // hold target position
	logic [15:0] ramp_up_q;       // stored ramp-up rate
	logic [15:0] ramp_dn_q;       // stored ramp-down rate
	logic [15:0] deadband_q [4];  // per-axis deadband
	logic [15:0] gain_q [4];      // per-axis hold gain
	logic [15:0] sv_deadband_q [4]; // saved deadband
	logic [15:0] sv_gain_q [4];     // saved gain
	logic [3:0]  home_pol_q;      // home switch true level
	logic [3:0]  sv_home_pol_q;   // saved switch level
	logic [11:0] enc_pol_q;       // idx,a,b true levels per axis
	logic [11:0] sv_enc_pol_q;    // saved encoder levels
	logic [3:0]  enc_home_q;      // encoder qualified homing
	// state
	logic [3:0]  hold_q;          // stepper-encoder hold on
	logic [3:0]  loop_q;          // servo loop closed
	logic        rej_q;           // range rejection sticky
	logic        bad_q;           // invalid command sticky
	logic [3:0]  cost_cmd_q;      // last command queue cost
	logic [3:0]  cost_arg_q;      // last argument queue cost

	// synchronised pins
	logic [3:0] sw_s;
	logic [3:0] idx_s;
	logic [3:0] a_s;
	logic [3:0] b_s;

	pin_sync #(.WIDTH(16)) u_sync (
		.REF_CLK (REF_CLK),
		.RST     (RST),
		.PIN_IN  ({HOME_SW, ENC_IDX, ENC_A, ENC_B}),
		.PIN_OUT ({sw_s, idx_s, a_s, b_s})
	);

	// bus decode
	wire         wr_ctrl = WR && ADDR == axis_hold_pkg::OFS_CTRL;
	wire         wr_kind = WR && ADDR == axis_hold_pkg::OFS_TYPES;
	wire         wr_cmd  = WR && ADDR == axis_hold_pkg::OFS_COMMAND;
	wire         wr_db   = WR && ADDR == axis_hold_pkg::OFS_DEADBAND;
	wire         wr_gain = WR && ADDR == axis_hold_pkg::OFS_GAIN;
	wire         wr_vcap = WR && ADDR == axis_hold_pkg::OFS_VCAP;
	wire         wr_stat = WR && ADDR == axis_hold_pkg::OFS_STATUS;
	wire         wr_tgt  = WR && ADDR == axis_hold_pkg::OFS_TARGET;
	wire         wr_rup  = WR && ADDR == axis_hold_pkg::OFS_RAMP_UP;
	wire         wr_rdn  = WR && ADDR == axis_hold_pkg::OFS_RAMP_DN;
	wire [3:0]   op      = WDATA[3:0];
	wire [3:0]   cmask   = WDATA[axis_hold_pkg::CMD_MASK_LSB +: 4];
	wire [3:0]   vmask   = WDATA[axis_hold_pkg::VAL_MASK_LSB +: 4];
	wire [15:0]  val     = WDATA[15:0];
	wire         single  = mode_q == axis_hold_pkg::MODE_SINGLE;
	wire [1:0]   cur_kind = kinds_q[2*axis_q +: 2];
	wire         cur_fb  = cur_kind != axis_hold_pkg::KIND_STEP;
	wire         cur_se  = cur_kind == axis_hold_pkg::KIND_STEPEN;
	wire [3:0]   csel    = sel_axes(mode_q, axis_q, cmask);
	wire [3:0]   vsel    = sel_axes(mode_q, axis_q, vmask);
	wire         is_cmd  = wr_cmd && op != axis_hold_pkg::OP_NONE;

	// range checks
	wire db_ok   = val <= axis_hold_pkg::DEADBAND_MAX;            // RQ8
	wire gain_ok = val >= axis_hold_pkg::GAIN_MIN &&
		val <= axis_hold_pkg::GAIN_MAX;                          // RQ22
	wire rej_set = (wr_db && !db_ok) || (wr_gain && !gain_ok);     // RQ23

	// go asymmetric legality: single axis modes only
	wire go_cmd  = wr_cmd && op == axis_hold_pkg::OP_GO_ASYM;
	wire go_ok   = go_cmd && single;                                // RQ2
	wire bad_set = go_cmd && !single;                               // RQ2

	// hold off target set: current axis in single mode, else all axes unless arguments given
	wire hf_cmd  = wr_cmd && op == axis_hold_pkg::OP_HOLD_OFF;
	wire [3:0] hf_sel = single ? csel :
		(cmask == 4'h0) ? 4'hF :                                   // RQ16
		cmask;                                                      // RQ17

	// queue cost of the command being written
	wire [3:0] go_cc = axis_hold_pkg::COST_GO_BASE +                // RQ4
		(cur_fb ? axis_hold_pkg::COST_FB_CMD : 4'h0) +
		(pa_q ? axis_hold_pkg::COST_PA_CMD : 4'h0) +                // RQ5
		(settle_q ? axis_hold_pkg::COST_SET_CMD : 4'h0);            // RQ6
	wire [3:0] go_ca = (cur_fb ? axis_hold_pkg::COST_FB_ARG : 4'h0) +
		(settle_q ? axis_hold_pkg::COST_SET_ARG : 4'h0);            // RQ6
	wire cur_sv = cur_kind == axis_hold_pkg::KIND_SERVO;
	wire [3:0] hf_cc = cur_sv ? axis_hold_pkg::COST_HF_SV_CMD :
		axis_hold_pkg::COST_HF_ST_CMD;                              // RQ19
	wire [3:0] hf_ca = cur_sv ? axis_hold_pkg::COST_HF_SV_ARG : 4'h0;

	// mode, kind and scalar settings
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			mode_q    <= axis_hold_pkg::MODE_SINGLE;
			axis_q    <= 2'h0;
			pa_q      <= 1'b0;
			settle_q  <= 1'b0;
			kinds_q   <= 8'h00;
			vcap_q    <= axis_hold_pkg::VCAP_RST;
			target_q  <= 32'h0000_0000;
			ramp_up_q <= 16'h0000;
			ramp_dn_q <= 16'h0000;
		end
		else
		begin
			if (wr_ctrl)
			begin
				mode_q   <= WDATA[axis_hold_pkg::CTRL_MODE_LSB +: 2];
				axis_q   <= WDATA[axis_hold_pkg::CTRL_AXIS_LSB +: 2];
				pa_q     <= WDATA[axis_hold_pkg::CTRL_PA_BIT];
				settle_q <= WDATA[axis_hold_pkg::CTRL_SET_BIT];
			end
			if (wr_kind)
				kinds_q <= WDATA[7:0];
			if (wr_vcap)
				vcap_q <= val;
			if (wr_tgt)
				target_q <= WDATA;
			if (wr_rup)
				ramp_up_q <= val;
			if (wr_rdn)
				ramp_dn_q <= val;
		end
	end

	// saved power-up values: only the power-on reset restores factory
	always_ff @(posedge REF_CLK)
	begin
		if (PWR_ON_RST)
		begin
			for (int i = 0; i < 4; i++)
			begin
				sv_deadband_q[i] <= axis_hold_pkg::DEADBAND_RST; // RQ8
				sv_gain_q[i]     <= axis_hold_pkg::GAIN_RST;     // RQ22
			end
			sv_home_pol_q <= {4{axis_hold_pkg::HOME_POL_RST}};
			sv_enc_pol_q  <= {4{axis_hold_pkg::ENC_POL_RST}};
		end
		else if (wr_cmd && op == axis_hold_pkg::OP_SAVE)
		begin
			for (int i = 0; i < 4; i++)
			begin
				sv_deadband_q[i] <= deadband_q[i];              // RQ8
				sv_gain_q[i]     <= gain_q[i];                  // RQ22
			end
			sv_home_pol_q <= home_pol_q;
			sv_enc_pol_q  <= enc_pol_q;
		end
	end

	// working deadband, gain and home configuration
	always_ff @(posedge REF_CLK)
	begin
		if (RST || PWR_ON_RST)
		begin
			for (int i = 0; i < 4; i++)
			begin
				deadband_q[i] <= PWR_ON_RST ?
					axis_hold_pkg::DEADBAND_RST : sv_deadband_q[i];
				gain_q[i] <= PWR_ON_RST ?
					axis_hold_pkg::GAIN_RST : sv_gain_q[i];
			end
			home_pol_q <= PWR_ON_RST ?
				{4{axis_hold_pkg::HOME_POL_RST}} : sv_home_pol_q;
			enc_pol_q  <= PWR_ON_RST ?
				{4{axis_hold_pkg::ENC_POL_RST}} : sv_enc_pol_q;
			enc_home_q <= 4'h0;
		end
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				// a bad value leaves the old one in place
				if (wr_db && db_ok && vsel[i])
					deadband_q[i] <= val;                       // RQ23
				if (wr_gain && gain_ok && vsel[i])
					gain_q[i] <= val;                           // RQ23
				if (wr_cmd && csel[i])
				begin
					case (op)
						axis_hold_pkg::OP_HOME_ENC:
							enc_home_q[i] <= 1'b1;                  // RQ10
						axis_hold_pkg::OP_HOME_SW:
							enc_home_q[i] <= 1'b0;                  // RQ12
						axis_hold_pkg::OP_HOME_LO:
							home_pol_q[i] <= 1'b0;                  // RQ13
						axis_hold_pkg::OP_HOME_HI:
							home_pol_q[i] <= 1'b1;                  // RQ13
						axis_hold_pkg::OP_ENC_POL:
							enc_pol_q[3*i +: 3] <=
								WDATA[axis_hold_pkg::CMD_POL_LSB +: 3]; // RQ13
						default:
							enc_home_q[i] <= enc_home_q[i];
					endcase
				end
			end
		end
	end

	// feedback state: hold on closes, hold off opens
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			hold_q <= 4'h0;                                         // RQ18
			loop_q <= 4'h0;                                         // RQ18
		end
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (hf_cmd && hf_sel[i])
				begin
					hold_q[i] <= 1'b0;                              // RQ14
					loop_q[i] <= 1'b0;                              // RQ15
				end
				else if (wr_cmd && op == axis_hold_pkg::OP_HOLD_ON &&
					csel[i])
				begin
					hold_q[i] <= kinds_q[2*i +: 2] ==
						axis_hold_pkg::KIND_STEPEN;
					loop_q[i] <= kinds_q[2*i +: 2] ==
						axis_hold_pkg::KIND_SERVO;
				end
			end
		end
	end

	// sticky flags: a new event beats a clear in the same cycle
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			rej_q <= 1'b0;
			bad_q <= 1'b0;
		end
		else
		begin
			rej_q <= rej_set ||
				(rej_q && !(wr_stat && WDATA[axis_hold_pkg::ST_REJ_BIT]));
			bad_q <= bad_set ||
				(bad_q && !(wr_stat && WDATA[axis_hold_pkg::ST_BAD_BIT]));
		end
	end

	// queue cost bookkeeping for the last command
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			cost_cmd_q <= 4'h0;
			cost_arg_q <= 4'h0;
		end
		else if (go_ok)
		begin
			cost_cmd_q <= go_cc;                                    // RQ4
			cost_arg_q <= go_ca;                                    // RQ4
		end
		else if (hf_cmd)
		begin
			cost_cmd_q <= hf_cc;                                    // RQ19
			cost_arg_q <= hf_ca;                                    // RQ19
		end
		else if (is_cmd && !go_cmd)
		begin
			cost_cmd_q <= 4'h0;
			cost_arg_q <= 4'h0;
		end
	end

	// move launch: rates latched with the start pulse
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			GO_START   <= 1'b0;
			ACCEL_RATE <= 16'h0000;
			DECEL_RATE <= 16'h0000;
		end
		else
		begin
			GO_START <= go_ok;
			if (go_ok)
			begin
				ACCEL_RATE <= ramp_up_q;                            // RQ1
				DECEL_RATE <= ramp_dn_q;                            // RQ1
			end
		end
	end

	// position correction for the current axis
	wire [31:0] perr    = target_q - ENC_COUNT;
	wire [31:0] pmag    = mag(perr);
	wire [15:0] cur_db  = deadband_q[axis_q];
	wire [15:0] cur_g   = gain_q[axis_q];
	wire        in_band = pmag <= {16'h0000, cur_db};               // RQ7
	wire [47:0] prod    = pmag * cur_g;                             // RQ20
	wire [15:0] vclamp  = (prod > {32'h0000_0000, vcap_q}) ?
		vcap_q : prod[15:0];                                        // RQ21
	wire        corr_on = hold_q[axis_q] && cur_se;

	// correction outputs; inside the deadband nothing moves
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			CORR_VEL    <= 16'h0000;
			CORR_DIR    <= 1'b0;
			IN_POSITION <= 1'b0;
		end
		else
		begin
			IN_POSITION <= corr_on && in_band;                      // RQ7
			CORR_VEL    <= (corr_on && !in_band) ? vclamp : 16'h0000;
			CORR_DIR    <= perr[31];
		end
	end

	// home qualification per axis
	logic [3:0] home_raw;
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			home_raw[i] = (sw_s[i] == home_pol_q[i]) &&        // RQ12
				(!enc_home_q[i] ||
				 ((idx_s[i] == enc_pol_q[3*i+2]) &&            // RQ11
				  (a_s[i] == enc_pol_q[3*i+1]) &&
				  (b_s[i] == enc_pol_q[3*i])));
	end

	// outputs from flops
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			HOME_FOUND  <= 4'h0;
			HOLD_EN     <= 4'h0;
			LOOP_CLOSED <= 4'h0;
		end
		else
		begin
			HOME_FOUND  <= home_raw;                                // RQ11
			HOLD_EN     <= hold_q;
			LOOP_CLOSED <= loop_q;
		end
	end

	// read selection; query only valid on single stepper-encoder
	wire        q_ok   = single && cur_se;                          // RQ9
	wire [31:0] rd_mux =
		(ADDR == axis_hold_pkg::OFS_CTRL) ?
			{26'h0, settle_q, pa_q, axis_q, mode_q} :
		(ADDR == axis_hold_pkg::OFS_TYPES) ? {24'h0, kinds_q} :
		(ADDR == axis_hold_pkg::OFS_DEADBAND) ?
			(q_ok ? {16'h0, cur_db} : 32'h0000_0000) :          // RQ9
		(ADDR == axis_hold_pkg::OFS_GAIN) ?
			(q_ok ? {16'h0, cur_g} : 32'h0000_0000) :
		(ADDR == axis_hold_pkg::OFS_VCAP) ? {16'h0, vcap_q} :
		(ADDR == axis_hold_pkg::OFS_STATUS) ?
			{16'h0, HOME_FOUND, 2'h0, bad_q, rej_q, loop_q, hold_q} :
		(ADDR == axis_hold_pkg::OFS_COST) ?
			{24'h0, cost_arg_q, cost_cmd_q} :
		(ADDR == axis_hold_pkg::OFS_TARGET) ? target_q :
		(ADDR == axis_hold_pkg::OFS_RAMP_UP) ? {16'h0, ramp_up_q} :
		(ADDR == axis_hold_pkg::OFS_RAMP_DN) ? {16'h0, ramp_dn_q} :
		(ADDR == axis_hold_pkg::OFS_HOMECFG) ?
			{16'h0, enc_pol_q[11:8], enc_home_q, home_pol_q,
			 enc_pol_q[3:0]} :
		32'h0000_0000;

	// read data valid the cycle after the strobe only
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			RDATA <= 32'h0000_0000;
		else
			RDATA <= RD ? rd_mux : 32'h0000_0000;
	end
endmodule // axis_hold_and_home_logic

/* File: sim/axis_hold_chk.sv */
// assertion checker for the axis hold and home logic
`timescale 1ns/10ps
module axis_hold_chk (
	input wire logic        REF_CLK,
	input wire logic        RST,
	input wire logic        PWR_ON_RST,
	input wire logic [3:0]  ADDR,
	input wire logic [31:0] WDATA,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [31:0] RDATA,
	input wire logic        GO_START,
	input wire logic [15:0] ACCEL_RATE,
	input wire logic [15:0] DECEL_RATE,
	input wire logic [3:0]  HOLD_EN,
	input wire logic [3:0]  LOOP_CLOSED,
	input wire logic [15:0] CORR_VEL,
	input wire logic        IN_POSITION
);
	logic [15:0] up_q;   // shadow of ramp-up rate
	logic [15:0] dn_q;   // shadow of ramp-down rate
	logic [15:0] vcap_q; // shadow of velocity cap
	logic [1:0]  mode_q; // shadow of operating mode
	wire wr_cmd = WR && ADDR == axis_hold_pkg::OFS_COMMAND;
	wire go_w   = wr_cmd && WDATA[3:0] == axis_hold_pkg::OP_GO_ASYM;
	wire off_w  = wr_cmd && WDATA[3:0] == axis_hold_pkg::OP_HOLD_OFF;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// shadows of host writes; plain reset clears them as in the design
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			up_q   <= 16'h0000;
			dn_q   <= 16'h0000;
			vcap_q <= axis_hold_pkg::VCAP_RST;
			mode_q <= axis_hold_pkg::MODE_SINGLE;
		end
		else if (WR)
		begin
			if (ADDR == axis_hold_pkg::OFS_RAMP_UP)
				up_q <= WDATA[15:0];
			if (ADDR == axis_hold_pkg::OFS_RAMP_DN)
				dn_q <= WDATA[15:0];
			if (ADDR == axis_hold_pkg::OFS_VCAP)
				vcap_q <= WDATA[15:0];
			if (ADDR == axis_hold_pkg::OFS_CTRL)
				mode_q <= WDATA[1:0];
		end
	end
	sequence go_req_s;
		go_w && mode_q == axis_hold_pkg::MODE_SINGLE;
	endsequence
	sequence all_off_s;
		off_w && WDATA[7:4] == 4'h0 && mode_q != axis_hold_pkg::MODE_SINGLE;
	endsequence
	go_cause_a: assert property (GO_START |-> $past(go_w) &&
		$past(mode_q) == axis_hold_pkg::MODE_SINGLE)
		else $error("go pulse without legal go command");
	go_pulse_a: assert property (go_req_s |=> GO_START ##1 !GO_START)
		else $error("go command gave no single pulse");
	ramp_latch_a: assert property (GO_START |->
		ACCEL_RATE == up_q && DECEL_RATE == dn_q)
		else $error("ramp rates not taken with go");
	ramp_hold_a: assert property (!GO_START |->
		$stable(ACCEL_RATE) && $stable(DECEL_RATE))
		else $error("ramp outputs moved without go");
	rd_idle_a: assert property (!RD |=> RDATA == 32'h0000_0000)
		else $error("read data outside answer cycle");
	hold_excl_a: assert property ((HOLD_EN & LOOP_CLOSED) == 4'h0)
		else $error("axis both hold and servo loop");
	all_open_a: assert property (all_off_s |-> ##[1:2]
		(HOLD_EN == 4'h0 && LOOP_CLOSED == 4'h0))
		else $error("multi-axis hold off left loops closed");
	rst_open_a: assert property ($fell(RST) |->
		HOLD_EN == 4'h0 && LOOP_CLOSED == 4'h0)
		else $error("feedback enabled after reset");
	pos_quiet_a: assert property (IN_POSITION |-> CORR_VEL == 16'h0000)
		else $error("correction inside deadband");
	vel_cap_a: assert property (vcap_q == $past(vcap_q, 2) |->
		CORR_VEL <= vcap_q)
		else $error("correction velocity above cap");
	idle_quiet_a: assert property (HOLD_EN == 4'h0 [*3] |->
		CORR_VEL == 16'h0000 && !IN_POSITION)
		else $error("correction without hold");
endmodule // axis_hold_chk

bind axis_hold_and_home_logic axis_hold_chk u_chk (
	.REF_CLK(REF_CLK), .RST(RST), .PWR_ON_RST(PWR_ON_RST),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
	.GO_START(GO_START), .ACCEL_RATE(ACCEL_RATE),
	.DECEL_RATE(DECEL_RATE), .HOLD_EN(HOLD_EN),
	.LOOP_CLOSED(LOOP_CLOSED), .CORR_VEL(CORR_VEL),
	.IN_POSITION(IN_POSITION)
);

/* File: sim/axis_pins_model.sv */
// far-side model: encoder counter and home and encoder pins
`timescale 1ns/10ps
module axis_pins_model (
	input  wire logic        clk,
	input  wire logic [31:0] pos_set,
	input  wire logic [15:0] pin_set,
	output logic      [31:0] enc_count,
	output logic      [3:0]  home_sw,
	output logic      [3:0]  enc_idx,
	output logic      [3:0]  enc_a,
	output logic      [3:0]  enc_b
);
	// pins move just after an edge, never mid-cycle
	always_ff @(posedge clk)
	begin
		enc_count <= pos_set;
		{enc_b, enc_a, enc_idx, home_sw} <= pin_set;
	end
endmodule // axis_pins_model

/* File: sim/tb_top.sv */
// self-checking bench for the axis hold and home logic
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
	logic        ref_clk = 1'b0;
	logic        rst     = 1'b1;
	logic        pwr_rst = 1'b1;
	logic [3:0]  addr    = 4'h0;
	logic [31:0] wdata   = 32'h0000_0000;
	logic        wr      = 1'b0;
	logic        rd      = 1'b0;
	logic [31:0] pos     = 32'h0000_0000; // encoder position
	logic [15:0] pins    = 16'h0000;      // {b, a, idx, switch}
	logic [31:0] rdata, enc_count, rv;
	logic [3:0]  home_sw, enc_idx, enc_a, enc_b;
	logic [3:0]  hold_en, loop_closed, home_found;
	logic [15:0] accel, decel, corr_vel;
	logic        go_start, corr_dir, in_pos;
	int          n_mismatch = 0;
	int          checks = 0;
	int          go_cnt = 0; // go pulses seen
	int          cyc = 0;
	int          n0, fb, m, v;
	int          tp[5] = '{997, 995, 990, 900, 1010};
	localparam logic [3:0] db = axis_hold_pkg::OFS_DEADBAND,
		gn = axis_hold_pkg::OFS_GAIN, st = axis_hold_pkg::OFS_STATUS,
		cost = axis_hold_pkg::OFS_COST; // short register indices
	axis_hold_and_home_logic dut (.REF_CLK(ref_clk), .RST(rst),
		.PWR_ON_RST(pwr_rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .ENC_COUNT(enc_count),
		.HOME_SW(home_sw), .ENC_IDX(enc_idx), .ENC_A(enc_a),
		.ENC_B(enc_b), .GO_START(go_start), .ACCEL_RATE(accel),
		.DECEL_RATE(decel), .HOLD_EN(hold_en),
		.LOOP_CLOSED(loop_closed), .CORR_VEL(corr_vel),
		.CORR_DIR(corr_dir), .IN_POSITION(in_pos),
		.HOME_FOUND(home_found));
	axis_pins_model far (.clk(ref_clk), .pos_set(pos), .pin_set(pins),
		.enc_count(enc_count), .home_sw(home_sw), .enc_idx(enc_idx),
		.enc_a(enc_a), .enc_b(enc_b));
	// 100 ns clock
	initial
		forever #50 ref_clk = ~ref_clk;
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// pulse counter and hang guard
	always @(posedge ref_clk)
	begin
		cyc++;
		if (go_start === 1'b1)
			go_cnt++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	// command and control writes: payload sits in the low bits
	task automatic cmd_w(input logic [11:0] c);
		wr_reg(axis_hold_pkg::OFS_COMMAND, {20'h0_0000, c});
	endtask
	task automatic ctl_w(input logic [5:0] c);
		wr_reg(axis_hold_pkg::OFS_CTRL, {26'h000_0000, c});
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a);
		@(posedge ref_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 rv = rdata;
	endtask
	task automatic expect_reg(input logic [3:0] a, input logic [31:0] e);
		rd_reg(a);
		`CHK(rv, e)
	endtask
	task automatic settle; // covers pin filter latency
		repeat (8) @(posedge ref_clk);
		#1;
	endtask
	task automatic home_step(input logic [15:0] p, input logic e);
		@(posedge ref_clk);
		pins <= p;
		settle();
		`CHK(home_found[0], e)
	endtask
	task automatic setup; // kinds: stepper+enc, servo, stepper, stepper+enc
		wr_reg(axis_hold_pkg::OFS_TYPES, 32'h0000_0049);
		ctl_w(6'h00);
	endtask
	initial
	begin
		repeat (5) @(posedge ref_clk);
		rst     <= 1'b0;
		pwr_rst <= 1'b0;
		settle();
		`CHK(hold_en | loop_closed, 4'h0)
		setup();
		expect_reg(db, 32'h0000_0000);
		expect_reg(gn, 32'h0000_0001);
		wr_reg(db, 32'h0000_FA00);
		wr_reg(db, 32'h0000_FA01);
		expect_reg(db, 32'h0000_FA00);
		rd_reg(st);
		`CHK(rv[8], 1'b1)
		wr_reg(gn, 32'h0000_7D00);
		wr_reg(gn, 32'h0000_0000);
		wr_reg(gn, 32'h0000_7D01);
		expect_reg(gn, 32'h0000_7D00);
		ctl_w(6'h02);
		expect_reg(db, 32'h0000_0000);
		// go on each axis, power automatic and settle varied
		for (int i = 0; i < 4; i++)
		begin
			fb = (i != 2);
			wr_reg(axis_hold_pkg::OFS_RAMP_UP, 32'(256 + i));
			wr_reg(axis_hold_pkg::OFS_RAMP_DN, 32'(512 + i));
			ctl_w(6'(i * 4 + i[0] * 16 + i[1] * 32));
			n0 = go_cnt;
			cmd_w(12'h001);
			settle();
			`CHK(go_cnt - n0, 1)
			`CHK(accel, 16'(256 + i))
			`CHK(decel, 16'(512 + i))
			m = 3 + fb + 2 * i[0] + 2 * i[1];
			v = 2 * fb + i[1];
			expect_reg(cost, 32'(v * 16 + m));
		end
		ctl_w(6'h01);
		n0 = go_cnt;
		cmd_w(12'h001);
		rd_reg(st);
		`CHK(rv[9], 1'b1)
		`CHK(go_cnt, n0)
		// single-axis hold on and off: servo, then stepper+enc
		ctl_w(6'h04);
		cmd_w(12'h003);
		settle();
		`CHK(loop_closed, 4'h2)
		cmd_w(12'h002);
		expect_reg(cost, 32'h0000_0011);
		`CHK(loop_closed, 4'h0)
		ctl_w(6'h00);
		cmd_w(12'h003);
		settle();
		`CHK(hold_en, 4'h1)
		cmd_w(12'h002);
		expect_reg(cost, 32'h0000_0002);
		`CHK(hold_en, 4'h0)
		// multi-axis: masked, then empty-argument hold off
		ctl_w(6'h01);
		cmd_w(12'h0F3);
		cmd_w(12'h012);
		settle();
		`CHK({hold_en, loop_closed}, 8'h82)
		cmd_w(12'h002);
		settle();
		`CHK({hold_en, loop_closed}, 8'h00)
		// correction on axis 0: deadband 5, gain 3, cap 100, target 1000
		ctl_w(6'h00);
		wr_reg(db, 32'h0000_0005);
		wr_reg(gn, 32'h0000_0003);
		wr_reg(axis_hold_pkg::OFS_VCAP, 32'h0000_0064);
		wr_reg(axis_hold_pkg::OFS_TARGET, 32'h0000_03E8);
		cmd_w(12'h003);
		foreach (tp[k])
		begin
			@(posedge ref_clk);
			pos <= 32'(tp[k]);
			settle();
			m = (tp[k] > 1000) ? tp[k] - 1000 : 1000 - tp[k];
			v = (m <= 5) ? 0 : ((m * 3 > 100) ? 100 : m * 3);
			`CHK(in_pos, 1'(m <= 5))
			`CHK(corr_vel, 16'(v))
			if (v != 0)
				`CHK(corr_dir, 1'(tp[k] > 1000))
		end
		// home on axis 0, switch true low from the factory
		n0 = go_cnt;
		home_step(16'h0000, 1'b1);
		cmd_w(12'h004);
		home_step(16'h0000, 1'b0);
		`CHK(go_cnt, n0)
		home_step(16'h0110, 1'b1);
		home_step(16'h1110, 1'b0);
		cmd_w(12'h007);
		home_step(16'h0111, 1'b1);
		home_step(16'h0110, 1'b0);
		cmd_w(12'h408);
		home_step(16'h0011, 1'b1);
		cmd_w(12'h005);
		home_step(16'h0111, 1'b1);
		cmd_w(12'h006);
		home_step(16'h0110, 1'b1);
		// saved settings survive a plain reset
		cmd_w(12'h009);
		wr_reg(db, 32'h0000_0009);
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		settle();
		`CHK(hold_en | loop_closed, 4'h0)
		setup();
		expect_reg(db, 32'h0000_0005);
		expect_reg(gn, 32'h0000_0003);
		tally_and_finish();
	end
endmodule // tb_top
